// ### shared/timer_pkg.sv
// constants and carrier types for the advanced timer time base
package timer_pkg;

   // ***************************************************************
   // register byte offsets (one aligned word each)
   // ***************************************************************
   localparam logic [7:0] OFS_CONTROL_ONE  = 8'h00;
   localparam logic [7:0] OFS_STATUS_ONE   = 8'h04;
   localparam logic [7:0] OFS_EVENT_GEN    = 8'h08;
   localparam logic [7:0] OFS_CNT_HIGH     = 8'h0c;
   localparam logic [7:0] OFS_CNT_LOW      = 8'h10;
   localparam logic [7:0] OFS_PSC_HIGH     = 8'h14;
   localparam logic [7:0] OFS_PSC_LOW      = 8'h18;
   localparam logic [7:0] OFS_ARR_HIGH     = 8'h1c;
   localparam logic [7:0] OFS_ARR_LOW      = 8'h20;
   localparam logic [7:0] OFS_REPEAT       = 8'h24;
   localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h28;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int unsigned BIT_RUN         = 0;
   localparam int unsigned BIT_HOLD_UPDATE = 1;
   localparam int unsigned BIT_SELECT      = 2;
   localparam int unsigned BIT_DIR         = 4;
   localparam int unsigned BIT_PRELOAD     = 7;
   localparam int unsigned BIT_GENERATE    = 0;
   localparam int unsigned BIT_FLAG        = 0;
   localparam int unsigned BIT_UIE         = 0;

   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [15:0] ARR_RST = 16'hffff;
   localparam logic [15:0] PSC_RST = 16'h0000;
   localparam logic [7:0]  RCR_RST = 8'h00;

   // ***************************************************************
   // carrier types
   // ***************************************************************
   typedef struct packed {
      logic reload_preload_enable;
      logic count_down;
      logic update_request_select;
      logic update_disable;
      logic counter_enable_bit;
   } ctrl_type;

   localparam ctrl_type CTRL_RST = '0;

endpackage : timer_pkg

// ### rtl/prescaler_divider.sv
// prescaler divider producing the divided count clock pulse
`timescale 1ns/1ps
`default_nettype none
module prescaler_divider #(
   parameter int unsigned WIDTH = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   input  wire logic             run,
   input  wire logic             restart,
   input  wire logic [WIDTH-1:0] ratio,
   output logic                  tick
);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      logic [WIDTH-1:0] count;
   } psc_state_type;

   psc_state_type st_ff;
   psc_state_type nxt_st;

   // divide by ratio plus one; ratio zero passes every cycle
   always_comb
   begin
      nxt_st = st_ff;
      tick   = run & (st_ff.count == ratio);
      if (restart)
      begin
         nxt_st.count = '0;
      end
      else if (tick)
      begin
         nxt_st.count = '0;
      end
      else if (run)
      begin
         nxt_st.count = st_ff.count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_ff <= '0;
      end
      else if (ce)
      begin
         st_ff <= nxt_st;
      end
   end

endmodule : prescaler_divider
`default_nettype wire

// ### rtl/advanced_timer_time_base.sv
// time base unit of the advanced timer with byte-wide apb register file
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - 16-bit up/down counter, auto-reload, prescaled clock
// - preload on: reload waits for update
// - preload off: reload shadow follows at once
// - update on wrap, software bit, trigger
// - update copies prescaler and reload preloads
// - count enable follows enable bit one cycle
// - counter byte writes load directly
// - high read latches low byte until read
// - reload high write blocks shadow until low
// - prescaler divides by value plus one
// - prescaler high first, applied after update
// - prescaler reads return preload value
// - up mode wraps to zero with update
// - update disable suppresses updates and copies
// - up mode software update restarts from zero
// - request select hides flag for software update
// - update refreshes buffers and sets flag
// - down mode reloads at zero with update
// - down mode software update reloads counter
// - reload shadow refreshed before counter reload
// - repetition count gates wrap updates
module advanced_timer_time_base (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        trigger_in,
   output logic             update_event_out,
   output logic             update_irq
);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      timer_pkg::ctrl_type ctrl;
      logic                irq_enable;
      logic [15:0]         arr_pre;
      logic [15:0]         arr_sh;
      logic                arr_block;
      logic [15:0]         psc_pre;
      logic [15:0]         psc_sh;
      logic                psc_block;
      logic [7:0]          rcr;
      logic [7:0]          rep;
      logic [15:0]         cnt;
      logic [7:0]          low_buf;
      logic                buf_valid;
      logic                internal_count_enable;
      logic                update_flag;
      logic                trig_s1;
      logic                trig_s2;
      logic                trig_s3;
      logic                upd_pulse;
      logic                irq;
      logic [31:0]         rdata;
      logic                ready;
      logic                slverr;
   } state_type;

   localparam state_type STATE_RST = '{
      ctrl: timer_pkg::CTRL_RST, irq_enable: 1'b0,
      arr_pre: timer_pkg::ARR_RST, arr_sh: timer_pkg::ARR_RST, arr_block: 1'b0,
      psc_pre: timer_pkg::PSC_RST, psc_sh: timer_pkg::PSC_RST, psc_block: 1'b0,
      rcr: timer_pkg::RCR_RST, rep: timer_pkg::RCR_RST, cnt: 16'h0000,
      low_buf: 8'h00, buf_valid: 1'b0, internal_count_enable: 1'b0,
      update_flag: 1'b0, trig_s1: 1'b0, trig_s2: 1'b0, trig_s3: 1'b0,
      upd_pulse: 1'b0, irq: 1'b0, rdata: 32'h0000_0000, ready: 1'b0, slverr: 1'b0};

   state_type st_ff;
   state_type nxt_st;

   logic divided_count_clock;
   logic counter_restart;
   logic acc;
   logic wr;
   logic rd;
   logic update_generate;
   logic trig_edge;
   logic wrap;
   logic hw_update;
   logic update_event;
   logic flag_set;
   logic flag_clear;

   // ***************************************************************
   // decode helpers
   // ***************************************************************
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == timer_pkg::OFS_CONTROL_ONE) || (a == timer_pkg::OFS_STATUS_ONE) ||
                  (a == timer_pkg::OFS_EVENT_GEN)   || (a == timer_pkg::OFS_CNT_HIGH)   ||
                  (a == timer_pkg::OFS_CNT_LOW)     || (a == timer_pkg::OFS_PSC_HIGH)   ||
                  (a == timer_pkg::OFS_PSC_LOW)     || (a == timer_pkg::OFS_ARR_HIGH)   ||
                  (a == timer_pkg::OFS_ARR_LOW)     || (a == timer_pkg::OFS_REPEAT)     ||
                  (a == timer_pkg::OFS_IRQ_ENABLE);
   endfunction : is_mapped

   function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] ofs);
      hit = strobe && (a == ofs);
   endfunction : hit

   // ***************************************************************
   // event sources, seen by the prescaler too
   // ***************************************************************
   // access handled in the first access cycle; pready follows one cycle later
   assign acc             = psel & penable & ~st_ff.ready;
   assign wr              = acc & pwrite;
   assign rd              = acc & ~pwrite;
   assign update_generate = hit(wr, paddr, timer_pkg::OFS_EVENT_GEN) &
                            pwdata[timer_pkg::BIT_GENERATE];
   assign trig_edge       = st_ff.trig_s2 & ~st_ff.trig_s3;
   assign counter_restart = update_generate | trig_edge;

   prescaler_divider #(
      .WIDTH (16)
   ) prescaler_divider_inst (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .run     (st_ff.internal_count_enable),
      .restart (counter_restart),
      .ratio   (st_ff.psc_sh),
      .tick    (divided_count_clock)
   );

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb
   begin
      nxt_st = st_ff;

      // trigger pin passes two flops before the edge detector
      nxt_st.trig_s1 = trigger_in;
      nxt_st.trig_s2 = st_ff.trig_s1;
      nxt_st.trig_s3 = st_ff.trig_s2;

      nxt_st.internal_count_enable = st_ff.ctrl.counter_enable_bit;

      wrap = divided_count_clock & st_ff.internal_count_enable &
             (st_ff.ctrl.count_down ? (st_ff.cnt == 16'h0000)
                                    : (st_ff.cnt == st_ff.arr_sh));
      hw_update = wrap & (st_ff.rep == 8'h00);
      if (wrap)
      begin
         nxt_st.rep = (st_ff.rep == 8'h00) ? st_ff.rcr : st_ff.rep - 8'h01;
      end
      if (counter_restart)
      begin
         nxt_st.rep = st_ff.rcr;
      end
      update_event = ~st_ff.ctrl.update_disable &
                     (hw_update | update_generate | trig_edge);

      // preload writes, byte wide, high byte first
      if (hit(wr, paddr, timer_pkg::OFS_ARR_HIGH))
      begin
         nxt_st.arr_pre[15:8] = pwdata[7:0];
         nxt_st.arr_block     = 1'b1;
      end
      if (hit(wr, paddr, timer_pkg::OFS_ARR_LOW))
      begin
         nxt_st.arr_pre[7:0] = pwdata[7:0];
         nxt_st.arr_block    = 1'b0;
      end
      if (hit(wr, paddr, timer_pkg::OFS_PSC_HIGH))
      begin
         nxt_st.psc_pre[15:8] = pwdata[7:0];
         nxt_st.psc_block     = 1'b1;
      end
      if (hit(wr, paddr, timer_pkg::OFS_PSC_LOW))
      begin
         nxt_st.psc_pre[7:0] = pwdata[7:0];
         nxt_st.psc_block    = 1'b0;
      end
      if (hit(wr, paddr, timer_pkg::OFS_REPEAT))
      begin
         nxt_st.rcr = pwdata[7:0];
      end
      if (hit(wr, paddr, timer_pkg::OFS_CONTROL_ONE))
      begin
         nxt_st.ctrl.counter_enable_bit    = pwdata[timer_pkg::BIT_RUN];
         nxt_st.ctrl.update_disable        = pwdata[timer_pkg::BIT_HOLD_UPDATE];
         nxt_st.ctrl.update_request_select = pwdata[timer_pkg::BIT_SELECT];
         nxt_st.ctrl.count_down            = pwdata[timer_pkg::BIT_DIR];
         nxt_st.ctrl.reload_preload_enable = pwdata[timer_pkg::BIT_PRELOAD];
      end
      if (hit(wr, paddr, timer_pkg::OFS_IRQ_ENABLE))
      begin
         nxt_st.irq_enable = pwdata[timer_pkg::BIT_UIE];
      end

      // shadow copies see this cycle's preload so a low-byte write lands at once
      if (!nxt_st.arr_block && (!st_ff.ctrl.reload_preload_enable || update_event))
      begin
         nxt_st.arr_sh = nxt_st.arr_pre;
      end
      if (!nxt_st.psc_block && update_event)
      begin
         nxt_st.psc_sh = nxt_st.psc_pre;
      end

      // counter; reload uses the fresh shadow so the next period is right
      if (counter_restart)
      begin
         nxt_st.cnt = st_ff.ctrl.count_down ? nxt_st.arr_sh : 16'h0000;
      end
      else if (wrap)
      begin
         nxt_st.cnt = st_ff.ctrl.count_down ? nxt_st.arr_sh : 16'h0000;
      end
      else if (divided_count_clock && st_ff.internal_count_enable)
      begin
         nxt_st.cnt = st_ff.ctrl.count_down ? st_ff.cnt - 16'h0001
                                            : st_ff.cnt + 16'h0001;
      end
      // direct byte loads win; a running counter may show a torn value
      if (hit(wr, paddr, timer_pkg::OFS_CNT_HIGH))
      begin
         nxt_st.cnt[15:8] = pwdata[7:0];
      end
      if (hit(wr, paddr, timer_pkg::OFS_CNT_LOW))
      begin
         nxt_st.cnt[7:0] = pwdata[7:0];
      end

      // sticky flag: a set in the clearing cycle wins
      flag_set   = update_event &
                   (hw_update | trig_edge | ~st_ff.ctrl.update_request_select);
      flag_clear = hit(wr, paddr, timer_pkg::OFS_STATUS_ONE) & ~pwdata[timer_pkg::BIT_FLAG];
      if (flag_clear)
      begin
         nxt_st.update_flag = 1'b0;
      end
      if (flag_set)
      begin
         nxt_st.update_flag = 1'b1;
      end
      nxt_st.upd_pulse = update_event;
      nxt_st.irq = nxt_st.update_flag & nxt_st.irq_enable;

      // apb answer
      nxt_st.ready  = acc;
      nxt_st.slverr = acc & ~is_mapped(paddr);
      if (rd)
      begin
         unique case (paddr)
            timer_pkg::OFS_CONTROL_ONE:
            begin
               nxt_st.rdata = {24'h000000, st_ff.ctrl.reload_preload_enable, 2'b00,
                               st_ff.ctrl.count_down, 1'b0, st_ff.ctrl.update_request_select,
                               st_ff.ctrl.update_disable, st_ff.ctrl.counter_enable_bit};
            end
            timer_pkg::OFS_STATUS_ONE: nxt_st.rdata = {31'h0, st_ff.update_flag};
            timer_pkg::OFS_CNT_HIGH:
            begin
               nxt_st.rdata     = {24'h000000, st_ff.cnt[15:8]};
               nxt_st.low_buf   = st_ff.cnt[7:0];
               nxt_st.buf_valid = 1'b1;
            end
            timer_pkg::OFS_CNT_LOW:
            begin
               nxt_st.rdata     = {24'h000000,
                                   st_ff.buf_valid ? st_ff.low_buf : st_ff.cnt[7:0]};
               nxt_st.buf_valid = 1'b0;
            end
            timer_pkg::OFS_PSC_HIGH:   nxt_st.rdata = {24'h000000, st_ff.psc_pre[15:8]};
            timer_pkg::OFS_PSC_LOW:    nxt_st.rdata = {24'h000000, st_ff.psc_pre[7:0]};
            timer_pkg::OFS_ARR_HIGH:   nxt_st.rdata = {24'h000000, st_ff.arr_pre[15:8]};
            timer_pkg::OFS_ARR_LOW:    nxt_st.rdata = {24'h000000, st_ff.arr_pre[7:0]};
            timer_pkg::OFS_REPEAT:     nxt_st.rdata = {24'h000000, st_ff.rcr};
            timer_pkg::OFS_IRQ_ENABLE: nxt_st.rdata = {31'h0, st_ff.irq_enable};
            default:                   nxt_st.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_ff <= STATE_RST;
      end
      else if (ce)
      begin
         st_ff <= nxt_st;
      end
   end

   assign prdata           = st_ff.rdata;
   assign pready           = st_ff.ready;
   assign pslverr          = st_ff.slverr;
   assign update_event_out = st_ff.upd_pulse;
   assign update_irq       = st_ff.irq;

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence high_read_s;
      ce && rd && (paddr == timer_pkg::OFS_CNT_HIGH);
   endsequence

   sequence frozen_s;
      st_ff.buf_valid && (st_ff.low_buf == $past(st_ff.cnt[7:0]));
   endsequence

   count_enable_lag_a: assert property (
      (ce && !st_ff.ctrl.counter_enable_bit && !st_ff.internal_count_enable)
      ##1 (ce && st_ff.ctrl.counter_enable_bit)
      |-> !st_ff.internal_count_enable ##1 st_ff.internal_count_enable)
      else $error("count enable did not follow enable bit by one cycle");

   reload_held_a: assert property (
      ($changed(st_ff.arr_sh) && $past(st_ff.ctrl.reload_preload_enable)) |-> st_ff.upd_pulse)
      else $error("reload shadow changed without an update");

   reload_direct_a: assert property (
      (ce && !st_ff.ctrl.reload_preload_enable && !st_ff.arr_block && !acc)
      |=> (st_ff.arr_sh == $past(st_ff.arr_pre)))
      else $error("reload shadow did not follow preload");

   update_quiet_a: assert property (
      (ce && st_ff.ctrl.update_disable) |=> !st_ff.upd_pulse)
      else $error("update raised while disabled");

   flag_hidden_a: assert property (
      (ce && update_generate && st_ff.ctrl.update_request_select &&
       !hw_update && !trig_edge && !st_ff.update_flag) |=> !st_ff.update_flag)
      else $error("flag set by hidden software update");

   up_wrap_a: assert property (
      (ce && wrap && !st_ff.ctrl.count_down && !counter_restart && !acc)
      |=> (st_ff.cnt == 16'h0000) ##1 (st_ff.cnt <= st_ff.arr_sh || !ce || acc))
      else $error("up count did not wrap to zero");

   down_reload_a: assert property (
      (ce && wrap && st_ff.ctrl.count_down && !counter_restart && !acc)
      |=> (st_ff.cnt == st_ff.arr_sh))
      else $error("down count did not reload from shadow");

   read_latch_a: assert property (
      high_read_s |=> frozen_s)
      else $error("low byte not latched by high read");

   flag_sticky_a: assert property (
      (ce && st_ff.update_flag && !flag_clear) |=> st_ff.update_flag ##1
       (st_ff.irq == (st_ff.update_flag && st_ff.irq_enable)))
      else $error("update flag dropped without a clear");

   soft_restart_a: assert property (
      (ce && update_generate && !st_ff.ctrl.count_down) |=> (st_ff.cnt == 16'h0000))
      else $error("software update did not restart counter");

endmodule : advanced_timer_time_base
`default_nettype wire

// ### dv/advanced_timer_time_base_test.sv
// self-checking bench for the advanced timer time base
`timescale 1ns/1ps
`default_nettype none
module advanced_timer_time_base_test;
   // ***************************************************************
   // stimulus, observation and model state
   // ***************************************************************
   localparam logic [7:0] CTL = timer_pkg::OFS_CONTROL_ONE;
   localparam logic [7:0] STA = timer_pkg::OFS_STATUS_ONE;
   localparam logic [7:0] EGN = timer_pkg::OFS_EVENT_GEN;
   localparam logic [7:0] CNT = timer_pkg::OFS_CNT_HIGH;
   localparam logic [7:0] PSC = timer_pkg::OFS_PSC_HIGH;
   localparam logic [7:0] ARR = timer_pkg::OFS_ARR_HIGH;
   logic        pclk;
   logic        presetn;
   logic        ce;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        trigger_in;
   logic        update_event_out;
   logic        update_irq;
   logic [7:0]  rd_q;
   logic        rd_err;
   int          err_count;
   int          check_count;
   int          cyc;
   int          a_val;
   int          p_val;
   int          per;
   int          pulses[$];

   advanced_timer_time_base advanced_timer_time_base_inst (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .trigger_in(trigger_in),
      .update_event_out(update_event_out), .update_irq(update_irq));

   // ***************************************************************
   // shared tasks
   // ***************************************************************
   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      rd_q = prdata[7:0];
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20)
      begin
         err_count++;
         stop_test();
      end
   endtask : apb

   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask : wr8

   task automatic rd8(input logic [7:0] a);
      apb(1'b0, a, 8'h00);
   endtask : rd8

   // high byte first on both directions
   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      wr8(a, v[15:8]);
      wr8(a + 8'h04, v[7:0]);
   endtask : wr16

   task automatic rd16(input logic [7:0] a, output logic [15:0] v);
      rd8(a);
      v[15:8] = rd_q;
      rd8(a + 8'h04);
      v[7:0] = rd_q;
   endtask : rd16

   function automatic logic [7:0] ctl(input logic run, hold, quiet, down, pre);
      logic [7:0] c;
      c = 8'h00;
      c[timer_pkg::BIT_RUN] = run;
      c[timer_pkg::BIT_HOLD_UPDATE] = hold;
      c[timer_pkg::BIT_SELECT] = quiet;
      c[timer_pkg::BIT_DIR] = down;
      c[timer_pkg::BIT_PRELOAD] = pre;
      return c;
   endfunction : ctl

   // bounded wait; a hang ends the run
   task automatic wait_pulses(input int n);
      int k;
      for (k = 0; k < 2000 && pulses.size() < n; k++)
         @(posedge pclk);
      if (k == 2000)
      begin
         err_count++;
         stop_test();
      end
   endtask : wait_pulses

   task automatic chk_gap(input int i, input int e);
      chk("pulse gap", 16'(e), 16'(pulses[i+1] - pulses[i]));
   endtask : chk_gap

   // ***************************************************************
   // clock and update pulse monitor
   // ***************************************************************
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      cyc++;
      if (update_event_out === 1'b1)
         pulses.push_back(cyc);
   end

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial
   begin
      logic [15:0] v;
      {presetn, psel, penable, pwrite, trigger_in} = 5'h0;
      {paddr, pwdata} = 40'h0;
      ce = 1'b1;
      err_count = 0;
      check_count = 0;
      cyc = 0;
      void'($urandom(32'h59b6));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd16(ARR, v);
      chk("reload reset", timer_pkg::ARR_RST, v);
      rd8(8'h2c);
      chk("unmapped error", 16'h0001, {15'h0, rd_err});
      wr16(CNT, 16'h1234);
      rd8(CNT);
      wr8(timer_pkg::OFS_CNT_LOW, 8'h99);
      rd8(timer_pkg::OFS_CNT_LOW);
      chk("latched low", 16'h0034, {8'h00, rd_q});
      rd16(CNT, v);
      chk("direct load", 16'h1299, v);
      wr8(EGN, 8'h01);
      rd16(CNT, v);
      chk("up restart", 16'h0000, v);
      wr16(ARR, 16'h000a);
      wr8(CTL, ctl(0, 0, 0, 1, 0));
      wr8(EGN, 8'h01);
      rd16(CNT, v);
      chk("down restart", 16'h000a, v);
      // random period, preload off so the reload lands at once
      a_val = 3 + $urandom % 6;
      p_val = $urandom % 3;
      per = (a_val + 1) * (p_val + 1);
      wr8(CTL, ctl(0, 0, 0, 0, 0));
      wr16(ARR, a_val[15:0]);
      wr16(PSC, p_val[15:0]);
      rd16(PSC, v);
      chk("prescaler read", p_val[15:0], v);
      wr8(EGN, 8'h01);
      wr8(CTL, ctl(1, 0, 0, 0, 0));
      pulses.delete();
      wait_pulses(3);
      chk_gap(1, per);
      // clock enable low freezes the count for exactly the frozen cycles
      pulses.delete();
      wait_pulses(1);
      ce <= 1'b0;
      repeat (20) @(posedge pclk);
      ce <= 1'b1;
      wait_pulses(2);
      chk_gap(0, per + 20);
      // a lone high byte must not reach the running reload
      wr8(ARR, 8'h01);
      pulses.delete();
      wait_pulses(3);
      chk_gap(1, per);
      wr16(ARR, a_val[15:0]);
      wr8(timer_pkg::OFS_REPEAT, 8'h01);
      pulses.delete();
      wait_pulses(3);
      chk_gap(1, 2 * per);
      wr8(timer_pkg::OFS_REPEAT, 8'h00);
      // down count, preloaded reload changed mid period
      wr8(CTL, ctl(1, 0, 0, 1, 1));
      wr16(ARR, 16'd20);
      wr8(EGN, 8'h01);
      repeat (4) @(posedge pclk);
      pulses.delete();
      wait_pulses(1);
      wr16(ARR, 16'd9);
      wait_pulses(3);
      chk_gap(0, 21 * (p_val + 1));
      chk_gap(1, 10 * (p_val + 1));
      wr8(CTL, ctl(1, 1, 0, 1, 1));
      wr16(ARR, 16'd4);
      repeat (2) @(posedge pclk);
      pulses.delete();
      repeat (200) @(posedge pclk);
      chk("pulses disabled", 16'h0000, 16'(pulses.size()));
      wr8(CTL, ctl(1, 0, 0, 1, 1));
      pulses.delete();
      wait_pulses(3);
      chk_gap(1, 5 * (p_val + 1));
      // flag, request select, interrupt and trigger
      wr8(CTL, ctl(0, 0, 1, 0, 0));
      wr8(timer_pkg::OFS_IRQ_ENABLE, 8'h01);
      wr8(STA, 8'h00);
      wr8(EGN, 8'h01);
      rd8(STA);
      chk("flag hidden", 16'h0000, {8'h00, rd_q});
      wr8(CTL, ctl(0, 0, 0, 0, 0));
      wr8(EGN, 8'h01);
      rd8(STA);
      chk("flag set", 16'h0001, {8'h00, rd_q});
      chk("irq high", 16'h0001, {15'h0, update_irq});
      wr8(STA, 8'h00);
      repeat (2) @(posedge pclk);
      chk("irq low", 16'h0000, {15'h0, update_irq});
      wr8(CTL, ctl(0, 0, 1, 0, 0));
      pulses.delete();
      trigger_in <= 1'b1;
      repeat (10) @(posedge pclk);
      chk("trigger pulse", 16'h0001, 16'(pulses.size()));
      rd8(STA);
      chk("trigger flag", 16'h0001, {8'h00, rd_q});
      trigger_in <= 1'b0;
      stop_test();
   end
endmodule : advanced_timer_time_base_test
`default_nettype wire
